/* File: hw/dsdt_timer.sv */
// Top of the dual set-point delay timer with its Avalon register slave
// Behaviour
// [R1] Selection mode entry clears count and outputs
// [R2] Selection choices apply on return to run
// [R3] Timer/twin change restores default set values
// [R4] Function mode keeps timing running
// [R5] Changed settings apply on run, clearing timer
// [R6] Key pair toggles sub-display set value
// [R7] Per-digit raise and lower keys
// [R8] Upper limit 1..999999, all indicators lit
// [R9] Input width long or short via key
// [R10] Selectable time base ranges
// [R11] Forecast: first output at set minus deviation
// [R12] Forecast: second output at set value
// [R13] Deviation at or above set: immediate
// [R14] Absolute: outputs at set values one, two
// [R15] ON-delay starts on rise, ignores restarts
// [R16] Start already high at power/reset starts
// [R17] ON-delay latches outputs, halts counting
// [R18] Zero set value asserts output immediately
// [R19] Cumulative counts while start and power on
// [R20] Cumulative latches outputs, keeps counting
// [R21] Run-time alarm in tenth years, zero off
// [R22] Switch-count alarm in thousands, zero off
// [R23] One width setting for all inputs
// [R24] Per-output normally open or closed
// [R25] External reset holds count and outputs off
`default_nettype none
module dsdt_timer #(
	parameter int unsigned MS_CYCLES   = dsdt_pkg::MS_CYCLES_DEF,
	parameter int unsigned LONG_CYC    = dsdt_pkg::LONG_WIDTH_MS * MS_CYCLES,
	parameter int unsigned SHORT_CYC   = dsdt_pkg::SHORT_WIDTH_MS * MS_CYCLES,
	parameter int unsigned TENTH_YR_MS = dsdt_pkg::TENTH_YEAR_MS
) (
	// Clock, reset, enable
	input  wire logic                   ref_clk,
	input  wire logic                   rst_b,
	input  wire logic                   ce,
	// Avalon-MM slave
	input  wire dsdt_pkg::dsdt_av_req_t avs_req,
	output logic [31:0]                 avs_readdata,
	output logic                        avs_waitrequest,
	// External inputs
	input  wire logic                   start_in,
	input  wire logic                   reset_in,
	input  wire logic                   gate_in,
	input  wire logic                   pwr_ok,
	// Switched outputs and indicators
	output logic                        first_output,
	output logic                        second_output,
	output logic                        replacement_alarm,
	output logic [5:0]                  key_led
);
	// Reset release synchroniser
	logic rst_s1_q, rst_n;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_q <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n    <= rst_s1_q;
		end
	end

	// State
	dsdt_pkg::dsdt_mode_t mode_q;           // Active mode
	dsdt_pkg::dsdt_cfg_t  cfg_q, pend_q;    // Active and pending config
	logic [23:0] sv_q [4];                  // Set values, {style, sel}
	logic [23:0] ulim_q, ulim_pend_q;       // Set value upper limit
	logic        item_q;                    // Function edit item
	logic        sel_q;                     // Sub-display choice
	logic [19:0] pv_q;                      // Present value, binary
	logic        running_q, done_q, started_q;
	logic        start_prev_q;              // For rise detection
	logic        first_output_q, second_output_q;            // Output latches
	logic [31:0] ms_div_q, unit_ms_q;       // Time base dividers
	logic [31:0] rt_ms_q;                   // Run-time divider
	logic [9:0]  rt_q, rt_thr_q;            // Run time, tenth years
	logic [23:0] sw_cnt_q;                  // Output switch count
	logic [13:0] cnt_thr_q;                 // Count alarm, thousands
	logic        pin1_q, pin2_q;            // Registered pins
	logic        ack_q;                     // Bus answer cycle
	logic [31:0] rdata_q;

	// Filtered inputs, one width setting for all three
	logic [2:0] raw_in, filt;
	assign raw_in = {gate_in, reset_in, start_in};
	for (genvar i = 0; i < 3; i++) begin : g_filt
		dsdt_in_filter #(
			.LONG_CYC (LONG_CYC),
			.SHORT_CYC(SHORT_CYC)
		) u_filt (
			.ref_clk  (ref_clk),
			.rst_n    (rst_n),
			.ce       (ce),
			.raw      (raw_in[i]),
			.short_sel(cfg_q.short_w),    // [R23] [R9]
			.level    (filt[i])
		);
	end
	wire start_f = filt[0];
	wire ext_rst = filt[1];
	wire gate_f  = filt[2];

	// Bus decode; one wait cycle, then the answer
	wire bus_req = avs_req.read | avs_req.write;
	wire take    = bus_req & ack_q;
	wire wr      = take & avs_req.write;
	wire [31:0] wd = avs_req.writedata;
	wire wr_mode = wr && avs_req.address == dsdt_pkg::OFF_MODE;
	wire wr_func = wr && avs_req.address == dsdt_pkg::OFF_FUNC;
	wire wr_key  = wr && avs_req.address == dsdt_pkg::OFF_KEY;
	wire wr_rt   = wr && avs_req.address == dsdt_pkg::OFF_RT_THR;
	wire wr_cnt  = wr && avs_req.address == dsdt_pkg::OFF_CNT_THR;
	assign avs_waitrequest = bus_req & ~ack_q;
	assign avs_readdata    = rdata_q;

	// Mode transitions
	wire [1:0] req_mode = wd[1:0];
	wire to_run = wr_mode && req_mode == 2'd0;
	wire func_ret = to_run && mode_q == dsdt_pkg::DSDT_FUNC;
	wire sel_ret  = to_run && mode_q == dsdt_pkg::DSDT_SEL;
	wire func_chg = (pend_q != cfg_q) || (ulim_pend_q != ulim_q);
	wire twin_chg = pend_q.twin != cfg_q.twin;
	wire func_apply = func_ret & func_chg;          // [R5]
	wire restore    = sel_ret & twin_chg;           // [R3]
	wire in_sel = mode_q == dsdt_pkg::DSDT_SEL;
	wire in_run = mode_q == dsdt_pkg::DSDT_RUN;
	wire in_fn  = mode_q == dsdt_pkg::DSDT_FUNC;

	// Everything that clears the count and the outputs
	wire clr_all = in_sel | ext_rst | func_apply | sel_ret  // [R1] [R25]
		| (~cfg_q.cumul & ~pwr_ok);

	// Set-point thresholds by style
	wire [1:0]  idx  = {cfg_q.absolute, sel_q};
	wire [19:0] s0 = dsdt_pkg::bcd2bin(sv_q[0]);
	wire [19:0] s1 = dsdt_pkg::bcd2bin(sv_q[1]);
	wire [19:0] s2 = dsdt_pkg::bcd2bin(sv_q[2]);
	wire [19:0] s3 = dsdt_pkg::bcd2bin(sv_q[3]);
	wire [19:0] main_bin = cfg_q.absolute ? s3 : s0;     // [R12] [R14]
	wire [19:0] fore_bin = (s1 >= s0) ? 20'h0 : s0 - s1; // [R11] [R13]
	wire [19:0] thr1 = cfg_q.absolute ? s2 : fore_bin;   // [R14]
	wire imm1 = cfg_q.absolute ? (s2 == 20'h0) : (s0 == 20'h0); // [R18]
	wire imm2 = main_bin == 20'h0;                       // [R18]
	wire hit_main = pv_q >= main_bin;

	// Time base tick from the millisecond divider
	wire ms_tick   = ms_div_q == MS_CYCLES - 1;
	wire [31:0] unit_len = {10'h0, dsdt_pkg::range_ms(cfg_q.range)}; // [R10]
	wire unit_tick = ms_tick && unit_ms_q >= unit_len - 32'h1;

	// Start handling and count enable
	wire start_rise = start_f & ~start_prev_q;
	wire od_take = ~cfg_q.cumul & start_rise & ~running_q & ~done_q; // [R15]
	wire cu_run  = cfg_q.cumul & start_f & pwr_ok;                   // [R19]
	wire od_run  = ~cfg_q.cumul & running_q & ~hit_main;             // [R17]
	wire count_en = unit_tick & ~gate_f & ~clr_all & (cu_run | od_run);
	wire [19:0] pv_inc = (pv_q == dsdt_pkg::PV_MAX) ? 20'h0 : pv_q + 20'h1;

	// Digit keys: each nibble has its own raise and lower key
	wire [5:0] k_up = wd[dsdt_pkg::KEY_RAISE_LSB +: 6];
	wire [5:0] k_dn = wd[dsdt_pkg::KEY_LOWER_LSB +: 6];
	wire [23:0] ed_src = in_fn ? ulim_pend_q : sv_q[idx];
	logic [23:0] ed_val;
	for (genvar d = 0; d < 6; d++) begin : g_digit
		wire [3:0] n = ed_src[d*4 +: 4];
		assign ed_val[d*4 +: 4] = k_up[d] ? ((n == 4'h9) ? 4'h0 : n + 4'h1)
			: k_dn[d] ? ((n == 4'h0) ? 4'h9 : n - 4'h1) : n;  // [R7]
	end
	wire key_tog = wr_key & wd[dsdt_pkg::KEY_TOGGLE] & in_run;      // [R6]
	wire key_sv  = wr_key & ~wd[dsdt_pkg::KEY_TOGGLE] & in_run
		& (dsdt_pkg::bcd2bin(ed_val) <= dsdt_pkg::bcd2bin(ulim_q));   // [R8]
	wire key_ul  = wr_key & in_fn & ~item_q
		& (ed_val >= dsdt_pkg::ULIM_MIN);                         // [R8]
	wire key_w   = wr_key & in_fn & item_q & (k_up[0] | k_dn[0]); // [R9]

	// Key indicators: all digits while editing the upper limit
	assign key_led = in_fn ? (item_q ? 6'h01 : 6'h3f)            // [R8]
		: in_run ? 6'h3f : 6'h00;

	// Bus handshake and read data
	wire [31:0] status = {22'h0, cfg_q.twin, cfg_q.absolute, sel_q,
		replacement_alarm, done_q, running_q, second_output_q, first_output_q,
		pin2_q, pin1_q};
	wire [5:0] ra = avs_req.address;
	wire [31:0] rd_mux =
		  ra == dsdt_pkg::OFF_MODE     ? {27'h0, item_q, 2'b0, mode_q}
		: ra == dsdt_pkg::OFF_FUNC     ? {22'h0, pend_q}
		: ra == dsdt_pkg::OFF_SV_MAIN  ? {8'h0, sv_q[{cfg_q.absolute, 1'b1}
			^ {1'b0, ~cfg_q.absolute}]}
		: ra == dsdt_pkg::OFF_SV_AUX   ? {8'h0, sv_q[{cfg_q.absolute,
			~cfg_q.absolute}]}
		: ra == dsdt_pkg::OFF_ULIM     ? {8'h0, ulim_q}
		: ra == dsdt_pkg::OFF_PV       ? {12'h0, pv_q}
		: ra == dsdt_pkg::OFF_STATUS   ? status
		: ra == dsdt_pkg::OFF_RT_THR   ? {22'h0, rt_thr_q}
		: ra == dsdt_pkg::OFF_CNT_THR  ? {18'h0, cnt_thr_q}
		: ra == dsdt_pkg::OFF_RUN_TIME ? {22'h0, rt_q}
		: ra == dsdt_pkg::OFF_SW_COUNT ? {8'h0, sw_cnt_q}
		: 32'h0;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q   <= 1'b0;
			rdata_q <= '0;
		end else if (ce) begin
			ack_q   <= bus_req & ~ack_q;
			rdata_q <= avs_req.read ? rd_mux : '0;
		end
	end

	// Mode and configuration; choices wait in the pending copy
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q      <= dsdt_pkg::DSDT_RUN;
			item_q      <= 1'b0;
			cfg_q       <= dsdt_pkg::CFG_RST;
			pend_q      <= dsdt_pkg::CFG_RST;
			ulim_q      <= dsdt_pkg::ULIM_RST;
			ulim_pend_q <= dsdt_pkg::ULIM_RST;
		end else if (ce) begin
			if (wr_mode) begin
				mode_q <= dsdt_pkg::dsdt_mode_t'(req_mode);
				item_q <= wd[dsdt_pkg::MODE_ITEM];
			end
			if (wr_func && in_fn)      // [R5]
				pend_q <= {pend_q.twin, wd[8:0]};
			else if (wr_func && in_sel)  // [R2]
				pend_q.twin <= wd[9];
			else if (key_w)
				pend_q.short_w <= ~pend_q.short_w;  // [R9]
			if (key_ul)
				ulim_pend_q <= ed_val;
			if (func_ret) begin        // [R5]
				cfg_q  <= {cfg_q.twin, pend_q[8:0]};
				ulim_q <= ulim_pend_q;
			end
			if (sel_ret)               // [R2]
				cfg_q.twin <= pend_q.twin;
		end
	end

	// Set values and sub-display selection
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sv_q  <= '{dsdt_pkg::SV_MAIN_RST, dsdt_pkg::SV_DEV_RST,
				dsdt_pkg::SV_MAIN_RST, dsdt_pkg::SV_MAIN_RST};
			sel_q <= 1'b0;
		end else if (ce) begin
			if (restore) begin         // [R3]
				sv_q  <= '{dsdt_pkg::SV_MAIN_RST, dsdt_pkg::SV_DEV_RST,
					dsdt_pkg::SV_MAIN_RST, dsdt_pkg::SV_MAIN_RST};
				sel_q <= 1'b0;
			end else begin
				if (key_tog)
					sel_q <= ~sel_q;    // [R6]
				if (key_sv)
					sv_q[idx] <= ed_val; // [R7]
			end
		end
	end

	// Timing core; function mode does not pause it
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pv_q         <= '0;
			running_q    <= 1'b0;
			done_q       <= 1'b0;
			started_q    <= 1'b0;
			start_prev_q <= 1'b0;
			first_output_q       <= 1'b0;
			second_output_q       <= 1'b0;
		end else if (ce) begin
			// Held low while cleared, so a high start reads as a rise
			start_prev_q <= clr_all ? 1'b0 : start_f;    // [R16]
			if (clr_all) begin                           // [R25] [R1]
				pv_q      <= '0;
				running_q <= 1'b0;
				done_q    <= 1'b0;
				started_q <= 1'b0;
				first_output_q    <= 1'b0;
				second_output_q    <= 1'b0;
			end else begin
				if (count_en)
					pv_q <= pv_inc;        // [R4] [R19] [R20]
				if (od_take)
					running_q <= 1'b1;     // [R15]
				else if (running_q && hit_main) begin
					running_q <= 1'b0;     // [R17]
					done_q    <= 1'b1;
				end
				started_q <= started_q | od_take | cu_run;
				first_output_q <= first_output_q | ((started_q | imm1) & pv_q >= thr1);
				second_output_q <= second_output_q | ((started_q | imm2) & hit_main);
			end
		end
	end

	// Output pins with inversion; registered
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin1_q <= 1'b0;
			pin2_q <= 1'b0;
		end else if (ce) begin
			pin1_q <= first_output_q ^ cfg_q.inv1;   // [R24]
			pin2_q <= second_output_q ^ cfg_q.inv2;   // [R24]
		end
	end
	assign first_output  = pin1_q;
	assign second_output = pin2_q;

	// Dividers, run time and switch count; these survive mode changes
	wire rt_step = ms_tick && pwr_ok && rt_ms_q >= TENTH_YR_MS - 1;
	wire sw_evt  = ((first_output_q ^ cfg_q.inv1) & ~pin1_q)
		| ((second_output_q ^ cfg_q.inv2) & ~pin2_q);
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ms_div_q  <= '0;
			unit_ms_q <= '0;
			rt_ms_q   <= '0;
			rt_q      <= '0;
			sw_cnt_q  <= '0;
			rt_thr_q  <= dsdt_pkg::RT_THR_RST;
			cnt_thr_q <= dsdt_pkg::CNT_THR_RST;
		end else if (ce) begin
			ms_div_q  <= ms_tick ? '0 : ms_div_q + 32'h1;
			unit_ms_q <= unit_tick ? '0
				: ms_tick ? unit_ms_q + 32'h1 : unit_ms_q;
			if (ms_tick && pwr_ok)
				rt_ms_q <= rt_step ? '0 : rt_ms_q + 32'h1;
			if (rt_step && rt_q != 10'h3e7)
				rt_q <= rt_q + 10'h1;                // [R21]
			if (sw_evt && sw_cnt_q != 24'hffffff)
				sw_cnt_q <= sw_cnt_q + 24'h1;        // [R22]
			if (wr_rt && wd[9:0] <= 10'h3e7)
				rt_thr_q <= wd[9:0];                 // [R21]
			if (wr_cnt && wd[13:0] <= 14'h270f)
				cnt_thr_q <= wd[13:0];               // [R22]
		end
	end
	wire [23:0] cnt_lim = 24'(cnt_thr_q * dsdt_pkg::CNT_UNIT);
	assign replacement_alarm = (rt_thr_q != 10'h0 && rt_q >= rt_thr_q)
		| (cnt_thr_q != 14'h0 && sw_cnt_q >= cnt_lim);  // [R21] [R22]

	// Checks
	chk_sel_clears_out: assert property (@(posedge ref_clk) // [R1]
		disable iff (!rst_n) (in_sel && ce) |=>
		(pv_q == 20'h0 && !first_output_q && !second_output_q))
		else $error("selection mode left count or outputs set");
	chk_twin_pending: assert property (@(posedge ref_clk) // [R2]
		disable iff (!rst_n) (!sel_ret) |=> cfg_q.twin == $past(cfg_q.twin))
		else $error("twin choice applied outside return to run");
	chk_restore_sv: assert property (@(posedge ref_clk) // [R3]
		disable iff (!rst_n) (restore && ce) |=>
		(sv_q[0] == dsdt_pkg::SV_MAIN_RST && sv_q[1] == dsdt_pkg::SV_DEV_RST))
		else $error("set values not restored on twin change");
	chk_func_counts: assert property (@(posedge ref_clk) // [R4]
		disable iff (!rst_n) (in_fn && ce && count_en) |=>
		pv_q == $past(pv_inc))
		else $error("function mode stopped timing");
	chk_apply_clears: assert property (@(posedge ref_clk) // [R5]
		disable iff (!rst_n) (func_apply && ce) |=>
		(pv_q == 20'h0 && !first_output_q && !second_output_q) ##1 !pin1_q ^ cfg_q.inv1)
		else $error("changed settings did not reset the timer");
	chk_ondelay_halts: assert property (@(posedge ref_clk) // [R17]
		disable iff (!rst_n) (!cfg_q.cumul && done_q && !clr_all && ce) |=>
		(pv_q == $past(pv_q) && second_output_q))
		else $error("ON-delay kept counting after time-up");
	chk_zero_output: assert property (@(posedge ref_clk) // [R18]
		disable iff (!rst_n) (imm2 && !clr_all && ce) |=> second_output_q)
		else $error("zero set value did not assert output");
	chk_ext_reset: assert property (@(posedge ref_clk) // [R25]
		disable iff (!rst_n) (ext_rst && ce)[*2] |->
		(pv_q == 20'h0 && !running_q && !first_output_q && !second_output_q))
		else $error("external reset did not hold the timer");
	chk_start_ignored: assert property (@(posedge ref_clk) // [R15]
		disable iff (!rst_n) (running_q && !clr_all && !hit_main && ce) |=>
		(running_q && started_q))
		else $error("start activity disturbed a running cycle");
endmodule // dsdt_timer
`default_nettype wire

/* File: hw/dsdt_pkg.sv */
// Shared constants, types and register map of the dual set-point delay timer
`default_nettype none
package dsdt_pkg;
	// Clock and base time figures
	localparam int unsigned CLK_PERIOD_NS  = 5;
	localparam int unsigned MS_NS          = 1000000;
	localparam int unsigned MS_CYCLES_DEF  = MS_NS / CLK_PERIOD_NS;
	localparam int unsigned LONG_WIDTH_MS  = 20;
	localparam int unsigned SHORT_WIDTH_MS = 1;
	// One tenth of a year in milliseconds (365.25 days)
	localparam int unsigned TENTH_YEAR_MS  = 32'd3155760000;

	// Register byte offsets on the Avalon slave
	localparam logic [5:0] OFF_MODE     = 6'h00;
	localparam logic [5:0] OFF_FUNC     = 6'h04;
	localparam logic [5:0] OFF_KEY      = 6'h08;
	localparam logic [5:0] OFF_SV_MAIN  = 6'h0c;
	localparam logic [5:0] OFF_SV_AUX   = 6'h10;
	localparam logic [5:0] OFF_ULIM     = 6'h14;
	localparam logic [5:0] OFF_PV       = 6'h18;
	localparam logic [5:0] OFF_STATUS   = 6'h1c;
	localparam logic [5:0] OFF_RT_THR   = 6'h20;
	localparam logic [5:0] OFF_CNT_THR  = 6'h24;
	localparam logic [5:0] OFF_RUN_TIME = 6'h28;
	localparam logic [5:0] OFF_SW_COUNT = 6'h2c;

	// Key register field positions
	localparam int unsigned KEY_RAISE_LSB = 0;
	localparam int unsigned KEY_LOWER_LSB = 6;
	localparam int unsigned KEY_TOGGLE    = 12;
	// Mode register: bits 1:0 requested mode, bit 4 edit item
	localparam int unsigned MODE_ITEM     = 4;

	// Values after reset, limits and the count unit
	localparam logic [23:0] SV_MAIN_RST   = 24'h000100;
	localparam logic [23:0] SV_DEV_RST    = 24'h000010;
	localparam logic [23:0] ULIM_RST      = 24'h999999;
	localparam logic [23:0] ULIM_MIN      = 24'h000001;
	localparam logic [9:0]  RT_THR_RST    = 10'h064;
	localparam logic [13:0] CNT_THR_RST   = 14'h0064;
	localparam logic [19:0] PV_MAX        = 20'h f423f;
	localparam logic [23:0] CNT_UNIT      = 24'h0003e8;

	// Operating modes
	typedef enum logic [1:0] {
		DSDT_RUN,
		DSDT_FUNC,
		DSDT_SEL
	} dsdt_mode_t;

	// Function configuration, pending and active copies
	typedef struct packed {
		logic       twin;       // Twin-timer use selected
		logic [3:0] range;      // Time base index
		logic       inv2;       // Second output normally closed
		logic       inv1;       // First output normally closed
		logic       short_w;    // Short input width
		logic       absolute;   // Absolute style, else forecast
		logic       cumul;      // Cumulative mode, else ON-delay
	} dsdt_cfg_t;
	localparam dsdt_cfg_t CFG_RST = '0;

	// Avalon-MM request carried as one bundle
	typedef struct packed {
		logic        read;
		logic        write;
		logic [5:0]  address;
		logic [31:0] writedata;
	} dsdt_av_req_t;

	// Milliseconds per count for each time base
	function automatic logic [21:0] range_ms(input logic [3:0] r);
		case (r)
			4'h0:    range_ms = 22'h000001;   // 0.001 s
			4'h1:    range_ms = 22'h00000a;   // 0.01 s
			4'h2:    range_ms = 22'h000064;   // 0.1 s
			4'h3:    range_ms = 22'h0003e8;   // 1 s
			4'h4:    range_ms = 22'h0003e8;   // h-min-s, seconds
			4'h5:    range_ms = 22'h001770;   // 0.1 min
			4'h6:    range_ms = 22'h00ea60;   // 1 min
			4'h7:    range_ms = 22'h00ea60;   // h-min, minutes
			4'h8:    range_ms = 22'h057e40;   // 0.1 h
			4'h9:    range_ms = 22'h36ee80;   // 1 h
			default: range_ms = 22'h0003e8;
		endcase
	endfunction

	// Six packed BCD digits to binary
	function automatic logic [19:0] bcd2bin(input logic [23:0] b);
		logic [23:0] acc;
		acc = '0;
		for (int i = 5; i >= 0; i--) begin
			acc = 24'(acc * 24'd10) + 24'(b[i*4 +: 4]);
		end
		bcd2bin = acc[19:0];
	endfunction
endpackage
`default_nettype wire

/* File: hw/dsdt_in_filter.sv */
// Width filter for one external input, clean level out
`default_nettype none
module dsdt_in_filter #(
	parameter int unsigned LONG_CYC  = 4000000,
	parameter int unsigned SHORT_CYC = 200000
) (
	// Clock, reset, enable
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic ce,
	// Input and setting
	input  wire logic raw,
	input  wire logic short_sel,
	// Filtered level
	output logic      level
);
	logic [31:0] cnt_q;      // Time the raw level differs
	logic        level_q;    // Accepted level
	wire  [31:0] limit = short_sel ? SHORT_CYC : LONG_CYC;
	wire  [31:0] cnt_inc = cnt_q + 32'h1;
	wire         differ = raw != level_q;

	// Chatter shorter than the width never reaches the timer
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q   <= '0;
			level_q <= 1'b0;
		end else if (ce) begin
			cnt_q   <= (differ && cnt_inc < limit) ? cnt_inc : '0;
			level_q <= (differ && cnt_inc >= limit) ? raw : level_q;
		end
	end

	assign level = level_q;
endmodule // dsdt_in_filter
`default_nettype wire

/* File: testbench/dsdt_ext_model.sv */
// Model of the external start, reset and gate signal sources
`default_nettype none
module dsdt_ext_model (
	// Clock
	input  wire logic ref_clk,
	// Input levels towards the timer
	output logic      start_in,
	output logic      reset_in,
	output logic      gate_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// All sources idle at power-up; gate stays open
	initial begin
		start_in = 1'b0;
		reset_in = 1'b0;
		gate_in  = 1'b0;
	end
	// Change levels just after an edge, then hold them for hold cycles
	// Holding longer than the width filter is what makes a change count
	task automatic drive(input logic [2:0] lv, input int hold);
		@(posedge ref_clk);
		{gate_in, reset_in, start_in} <= lv;
		repeat (hold) @(posedge ref_clk);
	endtask
endmodule // dsdt_ext_model
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench of the dual set-point delay timer
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// Clock, reset and bus request
	logic                   ref_clk;
	logic                   rst_b;
	dsdt_pkg::dsdt_av_req_t avs_req;
	logic [31:0]            rdata;
	logic [31:0]            pv_a;
	// Design outputs and external inputs
	logic [31:0]            avs_readdata;
	logic                   avs_waitrequest;
	logic                   start_in;
	logic                   reset_in;
	logic                   gate_in;
	logic                   pwr_ok;
	logic                   first_output;
	logic                   second_output;
	logic                   replacement_alarm;
	logic [5:0]             key_led;
	int                     fails;
	int                     num_checks;

	// Shortened counts keep the run to a few thousand cycles
	dsdt_timer #(.MS_CYCLES(10), .LONG_CYC(20), .SHORT_CYC(4),
		.TENTH_YR_MS(5)) u_dut (
		.ref_clk(ref_clk), .rst_b(rst_b), .ce(1'b1), .avs_req(avs_req),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.start_in(start_in), .reset_in(reset_in), .gate_in(gate_in),
		.pwr_ok(pwr_ok), .first_output(first_output),
		.second_output(second_output),
		.replacement_alarm(replacement_alarm), .key_led(key_led));
	// Far-side signal sources
	dsdt_ext_model u_ext (.ref_clk(ref_clk), .start_in(start_in),
		.reset_in(reset_in), .gate_in(gate_in));

	// 200 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask
	task automatic ok(input logic c, input string m);
		chk({31'h0, c}, 32'h1, m);
	endtask
	// One Avalon transfer; waitrequest and data are taken at the rising
	// edge, as the slave sees them, and the request drops right after it
	task automatic bus(input logic rd, input logic [5:0] a,
		input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_req <= '{read: rd, write: !rd, address: a, writedata: wd};
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		rdata = avs_readdata;
		ok(n < 100, "bus answer missing");
		avs_req <= '0;
	endtask
	task automatic rd_chk(input logic [5:0] a, input logic [31:0] e,
		input string m);
		bus(1'b1, a, '0);
		chk(rdata, e, m);
	endtask
	// Output pins as {first, second}, sampled mid-cycle
	task automatic pins(input logic [1:0] e, input string m);
		@(negedge ref_clk);
		chk({30'h0, first_output, second_output}, {30'h0, e}, m);
	endtask

	task automatic t_reset;
		rd_chk(dsdt_pkg::OFF_SV_MAIN, 32'h100, "set value");
		rd_chk(dsdt_pkg::OFF_SV_AUX, 32'h10, "deviation");
		rd_chk(dsdt_pkg::OFF_ULIM, 32'h999999, "limit");
		rd_chk(dsdt_pkg::OFF_RT_THR, 32'd100, "run-time limit");
		rd_chk(dsdt_pkg::OFF_CNT_THR, 32'd100, "count limit");
		rd_chk(6'h30, 32'h0, "unmapped read");
		chk({26'h0, key_led}, 32'h3f, "run leds");
		$display("test reset done");
	endtask
	// Forecast point 90, control point 100 counts of 10 cycles
	task automatic t_ondelay;
		u_ext.drive(3'b001, 880);
		pins(2'b00, "early output");
		u_ext.drive(3'b001, 80);
		pins(2'b10, "forecast output");
		u_ext.drive(3'b001, 140);
		pins(2'b11, "control output");
		rd_chk(dsdt_pkg::OFF_PV, 32'd100, "count not halted");
		u_ext.drive(3'b000, 40);
		u_ext.drive(3'b001, 40);
		rd_chk(dsdt_pkg::OFF_PV, 32'd100, "restart taken");
		pins(2'b11, "outputs not held");
		u_ext.drive(3'b011, 60);
		pins(2'b00, "reset outputs");
		rd_chk(dsdt_pkg::OFF_PV, 32'h0, "reset count");
		u_ext.drive(3'b001, 300);
		bus(1'b1, dsdt_pkg::OFF_PV, '0);
		ok(rdata > 0 && rdata < 100, "start after reset");
		$display("test on-delay done");
	endtask
	task automatic t_func;
		bus(1'b0, dsdt_pkg::OFF_MODE, 32'h1);
		@(negedge ref_clk);
		chk({26'h0, key_led}, 32'h3f, "limit leds");
		bus(1'b1, dsdt_pkg::OFF_PV, '0);
		pv_a = rdata;
		repeat (100) @(posedge ref_clk);
		bus(1'b1, dsdt_pkg::OFF_PV, '0);
		ok(rdata > pv_a, "timing stopped");
		bus(1'b0, dsdt_pkg::OFF_FUNC, 32'h1);
		bus(1'b0, dsdt_pkg::OFF_MODE, 32'h0);
		bus(1'b1, dsdt_pkg::OFF_PV, '0);
		ok(rdata < 2, "count not cleared");
		$display("test function done");
	endtask
	task automatic t_keys;
		bus(1'b0, dsdt_pkg::OFF_KEY, 32'h1);
		rd_chk(dsdt_pkg::OFF_SV_MAIN, 32'h101, "digit raise");
		bus(1'b0, dsdt_pkg::OFF_KEY, 32'h1000);
		bus(1'b0, dsdt_pkg::OFF_KEY, 32'h2);
		rd_chk(dsdt_pkg::OFF_SV_AUX, 32'h20, "sub toggle");
		$display("test keys done");
	endtask
	// Cumulative since the function test; set value now 101 counts
	task automatic t_cumul;
		repeat (1100) @(posedge ref_clk);
		pins(2'b11, "cumulative outputs");
		bus(1'b1, dsdt_pkg::OFF_PV, '0);
		ok(rdata > 32'd101, "count halted at time-up");
		pwr_ok <= 1'b0;
		bus(1'b1, dsdt_pkg::OFF_PV, '0);
		pv_a = rdata;
		repeat (50) @(posedge ref_clk);
		rd_chk(dsdt_pkg::OFF_PV, pv_a, "power-off count");
		pwr_ok <= 1'b1;
		u_ext.drive(3'b101, 30);
		bus(1'b1, dsdt_pkg::OFF_PV, '0);
		pv_a = rdata;
		u_ext.drive(3'b101, 50);
		rd_chk(dsdt_pkg::OFF_PV, pv_a, "gated count");
		u_ext.drive(3'b001, 30);
		$display("test cumulative done");
	endtask
	task automatic t_sel;
		bus(1'b0, dsdt_pkg::OFF_MODE, 32'h2);
		bus(1'b0, dsdt_pkg::OFF_FUNC, 32'h200);
		pins(2'b00, "selection outputs");
		bus(1'b1, dsdt_pkg::OFF_STATUS, '0);
		ok(rdata[9] === 1'b0, "twin applied early");
		bus(1'b0, dsdt_pkg::OFF_MODE, 32'h0);
		bus(1'b1, dsdt_pkg::OFF_STATUS, '0);
		ok(rdata[9] === 1'b1, "twin not applied");
		rd_chk(dsdt_pkg::OFF_SV_MAIN, 32'h100, "main restore");
		rd_chk(dsdt_pkg::OFF_SV_AUX, 32'h10, "aux restore");
		$display("test selection done");
	endtask
	// Run time is far past one tenth-year unit by now
	task automatic t_alarm;
		bus(1'b0, dsdt_pkg::OFF_RT_THR, 32'h0);
		@(negedge ref_clk);
		ok(replacement_alarm === 1'b0, "alarm off");
		bus(1'b0, dsdt_pkg::OFF_RT_THR, 32'h1);
		@(negedge ref_clk);
		ok(replacement_alarm === 1'b1, "alarm on");
		bus(1'b0, dsdt_pkg::OFF_RT_THR, 32'd1000);
		rd_chk(dsdt_pkg::OFF_RT_THR, 32'h1, "run limit range");
		bus(1'b0, dsdt_pkg::OFF_CNT_THR, 32'd10000);
		rd_chk(dsdt_pkg::OFF_CNT_THR, 32'd100, "count range");
		$display("test alarm done");
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		rst_b = 1'b0;
		avs_req = '0;
		pwr_ok = 1'b1;
		fails = 0;
		num_checks = 0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge ref_clk);
		t_reset;
		t_ondelay;
		t_func;
		t_keys;
		t_cumul;
		t_sel;
		t_alarm;
		give_verdict;
	end
	// Watchdog, about six and a half times the expected run
	initial begin
		#100000;
		fails++;
		$display("unexpected at %0t: watchdog", $time);
		give_verdict;
	end
endmodule // tb
`default_nettype wire
